// ### core/rsf_status_flags.sv
`timescale 1ns/100ps
// Function
// - Flag host FIFO writes during authentication or between last TX and RX bit.
// - Overheat sets its flag and switches antenna drivers off.
// - Flag any write attempt into a full FIFO.
// - Collision sets its flag; receiver start-up clears it.
// - Collision flag forced to zero at 212, 424 and 848 kBd.
// - CRC failure with checking enabled sets flag; receiver start-up clears it.
// - Parity failure sets flag, cleared at receiver start-up, valid at 106 kBd.
// - Bad start of frame sets framing flag, cleared at start-up, 106 kBd only.
// - Wrong byte count during authentication also sets framing flag.
// - Command start clears all error flags but overheat; software cannot set overheat.
// - CRC zero-result bit reads one when the CRC result is zero.
// - CRC zero-result is zero while calculating, one after correct completion.
// - CRC done sets when a compute command calculation finishes.
// - Interrupt pending shows any enabled interrupt source requesting.
// - Timer active reads one while the timer runs.
// - Gated mode: timer active follows timer enable, not gate level.
// - Near-full when 64 minus fill count is at most threshold.
// - Near-empty when fill count is at most threshold.
// - Any error bit becoming set raises the error event latch.
// - FIFO clear strobe resets pointers and clears overflow flag.
// - Latched near-full and near-empty events clear only by software.
module rsf_status_flags
	import rsf_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// Register port
	input wire logic [RSF_ADDR_W-1:0] reg_addr_in,
	input wire logic reg_read_in,
	input wire logic reg_write_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// Command sequencer
	input wire logic command_start_in,
	input wire logic card_authenticate_cmd_in,
	input wire logic crc_compute_cmd_in,
	// FIFO
	input wire logic host_fifo_write_in,
	input wire logic internal_fifo_write_in,
	input wire logic fifo_full_in,
	input wire logic fifo_clear_strobe_in,
	input wire logic [RSF_LEVEL_W-1:0] fifo_fill_count_in,
	input wire logic [RSF_THRESH_W-1:0] fifo_warning_threshold_in,
	output logic fifo_pointer_reset_out,
	// Receiver and transmitter
	input wire logic rf_last_tx_sent_in,
	input wire logic rf_last_rx_received_in,
	input wire logic rx_startup_in,
	input wire logic [1:0] rx_speed_in,
	input wire logic collision_detect_in,
	input wire logic rx_crc_check_enable_in,
	input wire logic rx_crc_fail_in,
	input wire logic parity_fail_in,
	input wire logic sof_error_in,
	input wire logic auth_byte_count_error_in,
	// Temperature
	input wire logic overheat_in,
	input wire logic overheat_clear_in,
	output logic antenna_drivers_off_out,
	// CRC coprocessor
	input wire logic crc_busy_in,
	input wire logic crc_finish_in,
	input wire logic crc_result_zero_in,
	// Interrupts
	input wire logic [7:0] main_irq_requests_in,
	input wire logic [7:0] main_interrupt_enables_in,
	input wire logic [7:0] aux_irq_requests_in,
	input wire logic [7:0] aux_interrupt_enables_in,
	input wire logic near_full_event_clear_in,
	input wire logic near_empty_event_clear_in,
	input wire logic error_event_clear_in,
	output logic error_event_latch_out,
	output logic fifo_near_full_event_out,
	output logic fifo_near_empty_event_out,
	// Timer
	input wire logic timer_running_in,
	input wire logic [1:0] timer_gate_select_in,
	input wire logic timer_enabled_in
);
	typedef struct packed {
		logic [7:0] rdata;
		logic err_event;
		logic ptr_reset;
		logic ant_off;
		rsf_crc_e crc_state;
		logic crc_zero;
		logic crc_done;
		logic irq;
		logic timer;
		logic in_rf_gap;
		logic [7:0] prev_err;
	} rsf_top_s;

	rsf_top_s state;
	rsf_top_s next_state;
	logic [7:0] err_set;
	logic [7:0] err_clr;
	logic [7:0] err_q;
	logic [7:0] err_view;
	logic [7:0] gen_view;
	logic near_full;
	logic near_empty;
	logic fifo_write_any;
	logic speed_106;

	always_comb begin
		speed_106 = rx_speed_in == RSF_SPEED_106;
		fifo_write_any = host_fifo_write_in | internal_fifo_write_in;
		err_set = 8'h00;
		err_clr = {8{command_start_in}} & ~(8'h01 << RSF_B_OVERHEAT);
		err_set[RSF_B_WRITE_VIOL] = host_fifo_write_in
			& (card_authenticate_cmd_in | state.in_rf_gap);
		err_set[RSF_B_OVERHEAT] = overheat_in;
		err_clr[RSF_B_OVERHEAT] = overheat_clear_in & ~overheat_in;
		err_set[RSF_B_FIFO_OVFL] = fifo_write_any & fifo_full_in;
		err_clr[RSF_B_FIFO_OVFL] = err_clr[RSF_B_FIFO_OVFL] | fifo_clear_strobe_in;
		err_set[RSF_B_COLLISION] = collision_detect_in & speed_106;
		err_clr[RSF_B_COLLISION] = err_clr[RSF_B_COLLISION] | rx_startup_in | ~speed_106;
		err_set[RSF_B_RX_CRC] = rx_crc_check_enable_in & rx_crc_fail_in;
		err_clr[RSF_B_RX_CRC] = err_clr[RSF_B_RX_CRC] | rx_startup_in;
		err_set[RSF_B_PARITY] = parity_fail_in & speed_106;
		err_clr[RSF_B_PARITY] = err_clr[RSF_B_PARITY] | rx_startup_in;
		err_set[RSF_B_FRAMING] = (sof_error_in & speed_106)
			| (card_authenticate_cmd_in & auth_byte_count_error_in);
		err_clr[RSF_B_FRAMING] = err_clr[RSF_B_FRAMING] | rx_startup_in;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_err
			if (gi == 5) begin : g_resv
				assign err_q[gi] = 1'b0;
			end else begin : g_flag
				rsf_err_bit u_bit (
					.clock_in(clock_in),
					.reset_in(reset_in),
					.set_in(err_set[gi]),
					.clear_in(err_clr[gi]),
					.flag_out(err_q[gi])
				);
			end
		end
	endgenerate

	rsf_fifo_watch #(
		.DEPTH(RSF_FIFO_DEPTH)
	) u_watch (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.fifo_fill_count_in(fifo_fill_count_in),
		.fifo_warning_threshold_in(fifo_warning_threshold_in),
		.near_full_event_clear_in(near_full_event_clear_in),
		.near_empty_event_clear_in(near_empty_event_clear_in),
		.fifo_near_full_out(near_full),
		.fifo_near_empty_out(near_empty),
		.fifo_near_full_event_out(fifo_near_full_event_out),
		.fifo_near_empty_event_out(fifo_near_empty_event_out)
	);

	always_comb begin
		err_view = err_q;
		gen_view = 8'h00;
		gen_view[RSF_B_CRC_ZERO] = state.crc_zero;
		gen_view[RSF_B_CRC_DONE] = state.crc_done;
		gen_view[RSF_B_IRQ] = state.irq;
		gen_view[RSF_B_TIMER] = state.timer;
		gen_view[RSF_B_NEAR_FULL] = near_full;
		gen_view[RSF_B_NEAR_EMPTY] = near_empty;
		next_state = state;
		next_state.prev_err = err_q;
		// Window from last transmitted bit to last received bit
		if (rf_last_tx_sent_in) begin
			next_state.in_rf_gap = 1'b1;
		end else if (rf_last_rx_received_in | command_start_in) begin
			next_state.in_rf_gap = 1'b0;
		end
		next_state.err_event = (|(err_q & ~state.prev_err))
			| (state.err_event & ~error_event_clear_in);
		next_state.ptr_reset = fifo_clear_strobe_in;
		if (err_q[RSF_B_OVERHEAT]) begin
			next_state.ant_off = 1'b1;
		end else begin
			next_state.ant_off = 1'b0;
		end
		case (state.crc_state)
			RSF_CRC_IDLE: begin
				if (crc_busy_in) begin
					next_state.crc_state = RSF_CRC_BUSY;
					next_state.crc_zero = 1'b0;
					next_state.crc_done = 1'b0;
				end
			end
			RSF_CRC_BUSY: begin
				next_state.crc_zero = 1'b0;
				if (crc_finish_in) begin
					next_state.crc_state = RSF_CRC_FINISHED;
					next_state.crc_zero = crc_result_zero_in;
					next_state.crc_done = crc_compute_cmd_in;
				end
			end
			RSF_CRC_FINISHED: begin
				next_state.crc_state = RSF_CRC_IDLE;
			end
			default: begin
				next_state.crc_state = RSF_CRC_IDLE;
			end
		endcase
		next_state.irq = |{main_irq_requests_in & main_interrupt_enables_in,
			aux_irq_requests_in & aux_interrupt_enables_in};
		if (timer_gate_select_in != 2'b00) begin
			next_state.timer = timer_enabled_in;
		end else begin
			next_state.timer = timer_running_in;
		end
		// Writes are accepted and dropped; status is read-only
		next_state.rdata = 8'h00;
		if (reg_read_in) begin
			case (reg_addr_in)
				RSF_OFF_ERROR_STATUS: begin
					next_state.rdata = err_view;
				end
				RSF_OFF_GENERAL_STATUS: begin
					next_state.rdata = gen_view;
				end
				default: begin
					next_state.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state <= '0;
			state.crc_zero <= RSF_RST_GENERAL_STATUS[RSF_B_CRC_ZERO];
			state.crc_done <= RSF_RST_GENERAL_STATUS[RSF_B_CRC_DONE];
			state.crc_state <= RSF_CRC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata_out = state.rdata;
	assign error_event_latch_out = state.err_event;
	assign fifo_pointer_reset_out = state.ptr_reset;
	assign antenna_drivers_off_out = state.ant_off;

	a_overflow_set: assert property (@(posedge clock_in) disable iff (reset_in)
		fifo_write_any && fifo_full_in |=> err_q[RSF_B_FIFO_OVFL])
		else $error("overflow flag not set");
	a_write_viol: assert property (@(posedge clock_in) disable iff (reset_in)
		host_fifo_write_in && card_authenticate_cmd_in |=> err_q[RSF_B_WRITE_VIOL])
		else $error("write violation not set");
	a_cmd_clears: assert property (@(posedge clock_in) disable iff (reset_in)
		command_start_in && !parity_fail_in |=> !err_q[RSF_B_PARITY])
		else $error("command start did not clear");
	a_collision_speed: assert property (@(posedge clock_in) disable iff (reset_in)
		rx_speed_in != RSF_SPEED_106 |=> !err_q[RSF_B_COLLISION])
		else $error("collision set at high speed");
	a_startup_crc: assert property (@(posedge clock_in) disable iff (reset_in)
		rx_startup_in && !rx_crc_fail_in |=> !err_q[RSF_B_RX_CRC])
		else $error("crc flag not cleared");
	a_antenna_off: assert property (@(posedge clock_in) disable iff (reset_in)
		overheat_in |=> ##1 antenna_drivers_off_out)
		else $error("antenna not off");
	a_err_event: assert property (@(posedge clock_in) disable iff (reset_in)
		$rose(err_q[RSF_B_PARITY]) |=> error_event_latch_out)
		else $error("error event missed");
	a_crc_busy: assert property (@(posedge clock_in) disable iff (reset_in)
		state.crc_state == RSF_CRC_BUSY && !crc_finish_in |=> !state.crc_zero)
		else $error("crc zero during busy");
	a_reserved_zero: assert property (@(posedge clock_in) disable iff (reset_in)
		$past(reg_read_in) |-> !reg_rdata_out[5] || $past(reg_addr_in) != RSF_OFF_ERROR_STATUS)
		else $error("reserved bit set");

	// Receive path flags and gap write violation
	a_collision_set: assert property (@(posedge clock_in) disable iff (reset_in)
		collision_detect_in && speed_106 |=> err_q[RSF_B_COLLISION])
		else $error("collision flag not set");
	a_collision_startup: assert property (@(posedge clock_in) disable iff (reset_in)
		rx_startup_in && !(collision_detect_in && speed_106) |=> !err_q[RSF_B_COLLISION])
		else $error("collision flag not cleared");
	a_crc_fail_set: assert property (@(posedge clock_in) disable iff (reset_in)
		rx_crc_check_enable_in && rx_crc_fail_in |=> err_q[RSF_B_RX_CRC])
		else $error("crc failure flag not set");
	a_parity_set: assert property (@(posedge clock_in) disable iff (reset_in)
		parity_fail_in && speed_106 |=> err_q[RSF_B_PARITY])
		else $error("parity flag not set");
	a_framing_sof: assert property (@(posedge clock_in) disable iff (reset_in)
		sof_error_in && speed_106 |=> err_q[RSF_B_FRAMING])
		else $error("framing flag not set");
	a_framing_auth: assert property (@(posedge clock_in) disable iff (reset_in)
		card_authenticate_cmd_in && auth_byte_count_error_in |=> err_q[RSF_B_FRAMING])
		else $error("byte count error not flagged");
	a_gap_write: assert property (@(posedge clock_in) disable iff (reset_in)
		host_fifo_write_in && state.in_rf_gap |=> err_q[RSF_B_WRITE_VIOL])
		else $error("gap write not flagged");
	// Overheat and antenna
	a_overheat_set: assert property (@(posedge clock_in) disable iff (reset_in)
		overheat_in |=> err_q[RSF_B_OVERHEAT])
		else $error("overheat flag not set");
	a_overheat_kept: assert property (@(posedge clock_in) disable iff (reset_in)
		err_q[RSF_B_OVERHEAT] && !overheat_clear_in |=> err_q[RSF_B_OVERHEAT])
		else $error("overheat flag lost");
	a_antenna_on: assert property (@(posedge clock_in) disable iff (reset_in)
		!err_q[RSF_B_OVERHEAT] |=> !antenna_drivers_off_out)
		else $error("antenna held off");
	// Status view
	a_crc_done_set: assert property (@(posedge clock_in) disable iff (reset_in)
		state.crc_state == RSF_CRC_BUSY && crc_finish_in
		|=> state.crc_done == $past(crc_compute_cmd_in))
		else $error("crc done wrong");
	a_crc_zero_done: assert property (@(posedge clock_in) disable iff (reset_in)
		state.crc_state == RSF_CRC_BUSY && crc_finish_in
		|=> state.crc_zero == $past(crc_result_zero_in))
		else $error("crc zero result wrong");
	a_irq_view: assert property (@(posedge clock_in) disable iff (reset_in)
		(|(main_irq_requests_in & main_interrupt_enables_in))
		|| (|(aux_irq_requests_in & aux_interrupt_enables_in)) |=> state.irq)
		else $error("interrupt pending missed");
	a_timer_free: assert property (@(posedge clock_in) disable iff (reset_in)
		timer_gate_select_in == 2'b00 |=> state.timer == $past(timer_running_in))
		else $error("timer active wrong");
	a_timer_gated: assert property (@(posedge clock_in) disable iff (reset_in)
		timer_gate_select_in != 2'b00 |=> state.timer == $past(timer_enabled_in))
		else $error("gated timer active wrong");
	// Events, FIFO clear and register port
	a_event_kept: assert property (@(posedge clock_in) disable iff (reset_in)
		error_event_latch_out && !error_event_clear_in |=> error_event_latch_out)
		else $error("error event lost");
	a_ptr_reset: assert property (@(posedge clock_in) disable iff (reset_in)
		fifo_clear_strobe_in && !(fifo_write_any && fifo_full_in)
		|=> fifo_pointer_reset_out && !err_q[RSF_B_FIFO_OVFL])
		else $error("fifo clear not applied");
	a_write_ignored: assert property (@(posedge clock_in) disable iff (reset_in)
		reg_write_in && !reg_read_in |=> reg_rdata_out == 8'h00)
		else $error("write produced read data");

	c_gap_write: cover property (@(posedge clock_in) host_fifo_write_in && state.in_rf_gap);
	c_antenna_off: cover property (@(posedge clock_in) antenna_drivers_off_out);
	c_overflow: cover property (@(posedge clock_in) err_q[RSF_B_FIFO_OVFL]);
	c_crc_done: cover property (@(posedge clock_in) state.crc_done && state.crc_zero);
	c_read_gen: cover property (@(posedge clock_in) reg_read_in
		&& reg_addr_in == RSF_OFF_GENERAL_STATUS);
endmodule : rsf_status_flags

// ### core/rsf_pkg.sv
package rsf_pkg;
	localparam int RSF_ADDR_W = 6;
	localparam logic [5:0] RSF_OFF_ERROR_STATUS = 6'h06;
	localparam logic [5:0] RSF_OFF_GENERAL_STATUS = 6'h07;
	localparam logic [7:0] RSF_RST_ERROR_STATUS = 8'h00;
	localparam logic [7:0] RSF_RST_GENERAL_STATUS = 8'h21;
	// Error status bit positions
	localparam int RSF_B_WRITE_VIOL = 7;
	localparam int RSF_B_OVERHEAT = 6;
	localparam int RSF_B_FIFO_OVFL = 4;
	localparam int RSF_B_COLLISION = 3;
	localparam int RSF_B_RX_CRC = 2;
	localparam int RSF_B_PARITY = 1;
	localparam int RSF_B_FRAMING = 0;
	// General status bit positions
	localparam int RSF_B_CRC_ZERO = 6;
	localparam int RSF_B_CRC_DONE = 5;
	localparam int RSF_B_IRQ = 4;
	localparam int RSF_B_TIMER = 3;
	localparam int RSF_B_NEAR_FULL = 1;
	localparam int RSF_B_NEAR_EMPTY = 0;
	// FIFO geometry
	localparam int RSF_FIFO_DEPTH = 64;
	localparam int RSF_LEVEL_W = 7;
	localparam int RSF_THRESH_W = 6;
	typedef enum logic [1:0] {
		RSF_SPEED_106 = 2'b00,
		RSF_SPEED_212 = 2'b01,
		RSF_SPEED_424 = 2'b10,
		RSF_SPEED_848 = 2'b11
	} rsf_speed_e;
	typedef enum logic [1:0] {
		RSF_CRC_IDLE = 2'b00,
		RSF_CRC_BUSY = 2'b01,
		RSF_CRC_FINISHED = 2'b10
	} rsf_crc_e;
endpackage : rsf_pkg

// ### core/rsf_fifo_watch.sv
`timescale 1ns/100ps
module rsf_fifo_watch
	import rsf_pkg::*;
#(
	parameter int DEPTH = RSF_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// FIFO state
	input wire logic [RSF_LEVEL_W-1:0] fifo_fill_count_in,
	input wire logic [RSF_THRESH_W-1:0] fifo_warning_threshold_in,
	// Software clears of the latched events
	input wire logic near_full_event_clear_in,
	input wire logic near_empty_event_clear_in,
	// Status
	output logic fifo_near_full_out,
	output logic fifo_near_empty_out,
	output logic fifo_near_full_event_out,
	output logic fifo_near_empty_event_out
);
	typedef struct packed {
		logic near_full;
		logic near_empty;
		logic full_event;
		logic empty_event;
	} rsf_watch_s;
	localparam logic [RSF_LEVEL_W:0] DEPTH_W = (RSF_LEVEL_W+1)'(DEPTH);
	rsf_watch_s state;
	rsf_watch_s next_state;
	logic [RSF_LEVEL_W:0] room;
	logic full_now;
	logic empty_now;
	always_comb begin
		room = DEPTH_W - {1'b0, fifo_fill_count_in};
		full_now = room <= {2'b00, fifo_warning_threshold_in};
		empty_now = fifo_fill_count_in <= {1'b0, fifo_warning_threshold_in};
		next_state = state;
		next_state.near_full = full_now;
		next_state.near_empty = empty_now;
		// Set wins over a clear in the same cycle
		next_state.full_event = full_now | (state.full_event & ~near_full_event_clear_in);
		next_state.empty_event = empty_now | (state.empty_event & ~near_empty_event_clear_in);
	end
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign fifo_near_full_out = state.near_full;
	assign fifo_near_empty_out = state.near_empty;
	assign fifo_near_full_event_out = state.full_event;
	assign fifo_near_empty_event_out = state.empty_event;
	a_near_full_eq: assert property (@(posedge clock_in) disable iff (reset_in)
		fifo_near_full_out == $past(full_now))
		else $error("near full wrong");
	a_event_sticky: assert property (@(posedge clock_in) disable iff (reset_in)
		$past(state.full_event) && !$past(near_full_event_clear_in) |-> state.full_event)
		else $error("near full event lost");
endmodule : rsf_fifo_watch

// ### core/rsf_err_bit.sv
`timescale 1ns/100ps
module rsf_err_bit (
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// Controls
	input wire logic set_in,
	input wire logic clear_in,
	// Flag
	output logic flag_out
);
	typedef struct packed {
		logic flag;
	} rsf_bit_s;
	rsf_bit_s state;
	rsf_bit_s next_state;
	always_comb begin
		next_state = state;
		// Set wins over clear
		next_state.flag = set_in | (state.flag & ~clear_in);
	end
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign flag_out = state.flag;
endmodule : rsf_err_bit

// ### testbench/rsf_host_model.sv
`timescale 1ns/100ps
module rsf_host_model
	import rsf_pkg::*;
(
	// Clock
	input wire logic clock_in,
	// Register port
	input wire logic [7:0] reg_rdata_in,
	output logic [RSF_ADDR_W-1:0] reg_addr_out,
	output logic reg_read_out,
	output logic reg_write_out,
	output logic [7:0] reg_wdata_out
);
	initial begin
		reg_addr_out = 6'h2a;
		reg_read_out = 1'h0;
		reg_write_out = 1'h0;
		reg_wdata_out = 8'h5a;
	end

	// One strobe per access; address and data are scrambled once released
	task automatic access(input logic [RSF_ADDR_W-1:0] addr, input logic wr,
		input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clock_in);
		#2;
		reg_addr_out = addr;
		reg_wdata_out = wd;
		reg_read_out = !wr;
		reg_write_out = wr;
		@(posedge clock_in);
		#2;
		reg_read_out = 1'h0;
		reg_write_out = 1'h0;
		reg_addr_out = ~addr;
		reg_wdata_out = ~wd;
		rd = reg_rdata_in;
	endtask : access
endmodule : rsf_host_model

// ### testbench/rsf_status_flags_bench.sv
`timescale 1ns/100ps
module rsf_status_flags_bench
	import rsf_pkg::*;
;
	logic clock_in = 1'h0, reset_in = 1'h1;
	logic [5:0] reg_addr_in;
	logic reg_read_in, reg_write_in;
	logic [7:0] reg_wdata_in, reg_rdata_out, d;
	logic command_start_in = 1'h0, card_authenticate_cmd_in = 1'h0, crc_compute_cmd_in = 1'h0;
	logic host_fifo_write_in = 1'h0, internal_fifo_write_in = 1'h0, fifo_full_in = 1'h0;
	logic fifo_clear_strobe_in = 1'h0, fifo_pointer_reset_out, antenna_drivers_off_out;
	logic [6:0] fifo_fill_count_in = 7'h00;
	logic [5:0] fifo_warning_threshold_in = 6'h00;
	logic error_event_latch_out, fifo_near_full_event_out, fifo_near_empty_event_out;
	logic rf_last_tx_sent_in = 1'h0, rf_last_rx_received_in = 1'h0, rx_startup_in = 1'h0;
	logic [1:0] rx_speed_in = 2'h0, timer_gate_select_in = 2'h0;
	logic collision_detect_in = 1'h0, rx_crc_check_enable_in = 1'h1, rx_crc_fail_in = 1'h0;
	logic parity_fail_in = 1'h0, sof_error_in = 1'h0, auth_byte_count_error_in = 1'h0;
	logic overheat_in = 1'h0, overheat_clear_in = 1'h0;
	logic crc_busy_in = 1'h0, crc_finish_in = 1'h0, crc_result_zero_in = 1'h0;
	logic [7:0] main_irq_requests_in = 8'h00, main_interrupt_enables_in = 8'h00;
	logic [7:0] aux_irq_requests_in = 8'h00, aux_interrupt_enables_in = 8'h00;
	logic near_full_event_clear_in = 1'h0, near_empty_event_clear_in = 1'h0;
	logic error_event_clear_in = 1'h0, timer_running_in = 1'h0, timer_enabled_in = 1'h0;
	logic [31:0] seed = 32'h0df5;
	logic [7:0] model_err = 8'h00;
	logic [7:0] mask [0:7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h01, 8'h80, 8'h10};
	int bad_count = 0, n_checks = 0, n_ptr = 0, m_zero = 0, m_done = 1;

	rsf_status_flags dut (.*);
	rsf_host_model host (.clock_in(clock_in), .reg_rdata_in(reg_rdata_out),
		.reg_addr_out(reg_addr_in), .reg_read_out(reg_read_in),
		.reg_write_out(reg_write_in), .reg_wdata_out(reg_wdata_in));

	always #25 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		if (fifo_pointer_reset_out === 1'h1) begin
			n_ptr++;
		end
	end

	task automatic tick();
		@(posedge clock_in);
		#2;
	endtask : tick

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] r;
		tick();
		host.access(a, 1'h0, 8'h00, r);
		chk(r, e);
	endtask : rd_chk

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Live general status as the rules define it
	function automatic logic [7:0] gen_exp();
		int r;
		r = (m_zero << 6) | (m_done << 5);
		r |= int'(|(main_irq_requests_in & main_interrupt_enables_in)
			| |(aux_irq_requests_in & aux_interrupt_enables_in)) << 4;
		r |= int'(timer_gate_select_in != 2'h0 ? timer_enabled_in : timer_running_in) << 3;
		r |= int'(64 - int'(fifo_fill_count_in) <= int'(fifo_warning_threshold_in)) << 1;
		r |= int'(int'(fifo_fill_count_in) <= int'(fifo_warning_threshold_in));
		return 8'(r);
	endfunction : gen_exp

	// Raise one event or control for a cycle, then drop it
	task automatic pulse(input int i);
		for (int v = 1; v >= 0; v--) begin
			case (i)
				0: sof_error_in = v[0];
				1: parity_fail_in = v[0];
				2: rx_crc_fail_in = v[0];
				3: collision_detect_in = v[0];
				4: {host_fifo_write_in, fifo_full_in} = {2{v[0]}};
				5: {auth_byte_count_error_in, card_authenticate_cmd_in} = {2{v[0]}};
				6: {host_fifo_write_in, card_authenticate_cmd_in} = {2{v[0]}};
				7: {internal_fifo_write_in, fifo_full_in} = {2{v[0]}};
				8: rf_last_tx_sent_in = v[0];
				9: rf_last_rx_received_in = v[0];
				10: host_fifo_write_in = v[0];
				11: command_start_in = v[0];
				12: rx_startup_in = v[0];
				13: fifo_clear_strobe_in = v[0];
				14: error_event_clear_in = v[0];
				15: overheat_clear_in = v[0];
				16: crc_finish_in = v[0];
				default: {near_full_event_clear_in, near_empty_event_clear_in} = {2{v[0]}};
			endcase
			tick();
		end
	endtask : pulse

	initial begin
		#2000000;
		bad_count++;
		end_of_test();
	end

	initial begin
		repeat (8) tick();
		reset_in = 1'h0;
		rd_chk(RSF_OFF_ERROR_STATUS, RSF_RST_ERROR_STATUS);
		rd_chk(RSF_OFF_GENERAL_STATUS, gen_exp());
		rd_chk(6'h3f, 8'h00);
		host.access(RSF_OFF_ERROR_STATUS, 1'h1, 8'hff, d);
		host.access(RSF_OFF_GENERAL_STATUS, 1'h1, 8'hff, d);
		rd_chk(RSF_OFF_ERROR_STATUS, 8'h00);
		rd_chk(RSF_OFF_GENERAL_STATUS, gen_exp());
		rx_crc_check_enable_in = 1'h0;
		pulse(2);
		rx_crc_check_enable_in = 1'h1;
		rd_chk(RSF_OFF_ERROR_STATUS, 8'h00);
		for (int i = 0; i < 8; i++) begin
			// Free the target bit first so that every event is seen rising
			if (i == 5) begin
				pulse(12);
				model_err &= 8'hf0;
			end else if (i == 7) begin
				pulse(13);
				model_err &= 8'hef;
			end
			pulse(i);
			model_err |= mask[i];
			rd_chk(RSF_OFF_ERROR_STATUS, model_err);
			chk({7'h00, error_event_latch_out}, 8'h01);
			pulse(14);
		end
		chk({7'h00, error_event_latch_out}, 8'h00);
		pulse(12);
		model_err &= 8'hf0;
		rd_chk(RSF_OFF_ERROR_STATUS, model_err);
		pulse(13);
		rd_chk(RSF_OFF_ERROR_STATUS, 8'h80);
		chk(8'(n_ptr), 8'h02);
		pulse(11);
		rd_chk(RSF_OFF_ERROR_STATUS, 8'h00);
		// Host write inside the transmit-to-receive gap only
		pulse(8);
		pulse(10);
		pulse(9);
		rd_chk(RSF_OFF_ERROR_STATUS, 8'h80);
		pulse(11);
		pulse(10);
		rd_chk(RSF_OFF_ERROR_STATUS, 8'h00);
		overheat_in = 1'h1;
		pulse(11);
		rd_chk(RSF_OFF_ERROR_STATUS, 8'h40);
		chk({7'h00, antenna_drivers_off_out}, 8'h01);
		overheat_in = 1'h0;
		pulse(15);
		rd_chk(RSF_OFF_ERROR_STATUS, 8'h00);
		chk({7'h00, antenna_drivers_off_out}, 8'h00);
		for (int j = 0; j < 2; j++) begin
			crc_busy_in = 1'h1;
			tick();
			m_zero = 0;
			m_done = 0;
			rd_chk(RSF_OFF_GENERAL_STATUS, gen_exp());
			crc_busy_in = 1'h0;
			crc_result_zero_in = j[0];
			crc_compute_cmd_in = j[0];
			pulse(16);
			m_zero = j;
			m_done = j;
			rd_chk(RSF_OFF_GENERAL_STATUS, gen_exp());
		end
		repeat (40) begin
			seed = lfsr(seed);
			main_irq_requests_in = seed[7:0];
			main_interrupt_enables_in = seed[15:8] & seed[23:16] & seed[31:24];
			aux_irq_requests_in = seed[15:8];
			aux_interrupt_enables_in = seed[7:0] & seed[23:16] & seed[31:24];
			seed = lfsr(seed);
			fifo_fill_count_in = 7'(seed[15:0] % 65);
			fifo_warning_threshold_in = seed[21:16];
			timer_gate_select_in = seed[23:22];
			timer_running_in = seed[24];
			timer_enabled_in = seed[25];
			rx_speed_in = seed[27:26];
			rd_chk(RSF_OFF_GENERAL_STATUS, gen_exp());
			pulse(3);
			rd_chk(RSF_OFF_ERROR_STATUS, seed[27:26] == 2'h0 ? 8'h08 : 8'h00);
			pulse(11);
		end
		fifo_fill_count_in = 7'h20;
		fifo_warning_threshold_in = 6'h04;
		tick();
		pulse(17);
		chk({6'h00, fifo_near_full_event_out, fifo_near_empty_event_out}, 8'h00);
		fifo_fill_count_in = 7'h3e;
		repeat (3) tick();
		fifo_fill_count_in = 7'h20;
		rd_chk(RSF_OFF_GENERAL_STATUS, gen_exp());
		chk({6'h00, fifo_near_full_event_out, fifo_near_empty_event_out}, 8'h02);
		end_of_test();
	end
endmodule : rsf_status_flags_bench
